// ===== hw/ipm_regs.svh
// Notes on behaviour
// - Converter power-down outranks microphone power-down.
// - Source: converter, microphone, or digital power off.
// - Gather pulse-density bits from one or two microphones.
// - Port is one clock output, one data input.
// - Channel A on rising, B on falling edge.
// - Port powered when any channel selects microphone.
// - Powered-off port holds bit clock low.
// - Bit clock is master divided by 2 or 4.
// - Divider serves the listed master clock rates.
// - Weak data pull stays on, avoiding mid-rail.
`ifndef IPM_REGS_SVH
`define IPM_REGS_SVH

// Divide ratios for the two settings of the divide select
`define IPM_DIV_LO 2
`define IPM_DIV_HI 4
// Divide select level picking the ratio of two
`define IPM_SEL_DIV_LO 1'b0
// Idle level of the bit clock
`define IPM_BCLK_IDLE 1'b0
// Weak pull request level on the data input
`define IPM_PULL_ON 1'b1
// Reset value of captured sample bits
`define IPM_BIT_RST 1'b0

`endif

// ===== hw/ipm_pkg.sv
package ipm_pkg;

  // Data source chosen for one input-path channel
  typedef enum logic [1:0] {
    IPM_SRC_ADC,
    IPM_SRC_MIC,
    IPM_SRC_NONE
  } ipm_src_t;

  // Whole state of the divider
  typedef struct packed {
    logic [2:0] cnt;
    logic phase;
    logic rise;
    logic fall;
  } ipm_div_st_t;

  // Whole state of the top module
  typedef struct packed {
    ipm_src_t src_a;
    ipm_src_t src_b;
    logic dig_on_a;
    logic dig_on_b;
    logic port_on;
    logic bclk;
    logic bit_a;
    logic samp_a;
    logic samp_b;
    logic valid;
    logic pull_en;
  } ipm_top_st_t;

endpackage

// ===== hw/ipm_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipm_regs.svh"

// Turns the master clock into rise and fall enable pulses for the bit clock
module ipm_clock_divider #(
  parameter int DIV_LO = `IPM_DIV_LO,
  parameter int DIV_HI = `IPM_DIV_HI
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic divide_select,
  output logic rise_pulse,
  output logic fall_pulse
);

  // Last count of each half period
  localparam logic [2:0] LO_LAST = 3'(DIV_LO / 2 - 1);
  localparam logic [2:0] HI_LAST = 3'(DIV_HI / 2 - 1);

  // Only even ratios give an even duty cycle; counter is three bits
  initial begin
    if (DIV_LO < 2 || DIV_LO > 16 || (DIV_LO % 2) != 0 ||
        DIV_HI < 2 || DIV_HI > 16 || (DIV_HI % 2) != 0) begin
      $error("ipm_clock_divider: ratios must be even, 2 to 16");
    end
  end

  ipm_pkg::ipm_div_st_t st_q; // Registered state
  ipm_pkg::ipm_div_st_t st_d; // Next state
  logic [2:0] last; // Half period end for the chosen ratio

  // Equal halves give both capture phases the same time
  always_comb begin
    st_d = st_q;
    st_d.rise = 1'b0;
    st_d.fall = 1'b0;
    // Pure ratio division, so any listed master rate is served alike
    last = (divide_select == `IPM_SEL_DIV_LO) ? LO_LAST : HI_LAST;
    if (!enable) begin
      // Restart from the low phase so a new burst opens with a rise
      st_d.cnt = 3'h0;
      st_d.phase = `IPM_BCLK_IDLE;
    end else if (st_q.cnt >= last) begin
      // Greater-or-equal copes with a ratio change mid-period
      st_d.cnt = 3'h0;
      st_d.phase = ~st_q.phase;
      st_d.rise = ~st_q.phase;
      st_d.fall = st_q.phase;
    end else begin
      st_d.cnt = st_q.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_pulse = st_q.rise;
  assign fall_pulse = st_q.fall;

endmodule // ipm_clock_divider
`default_nettype wire

// ===== hw/ipm_input_path.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipm_regs.svh"

// Input path source select and two-microphone pulse-density capture port
module ipm_input_path #(
  parameter int DIV_LO = `IPM_DIV_LO,
  parameter int DIV_HI = `IPM_DIV_HI
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic adc_powerdown_a,
  input wire logic adc_powerdown_b,
  input wire logic mic_powerdown_a,
  input wire logic mic_powerdown_b,
  input wire logic pdm_clock_divide_select,
  input wire logic pdm_data_in,
  output ipm_pkg::ipm_src_t path_a_source,
  output ipm_pkg::ipm_src_t path_b_source,
  output logic path_a_digital_power_on,
  output logic path_b_digital_power_on,
  output logic mic_port_power_on,
  output logic pdm_bit_clock_out,
  output logic pdm_data_pull_enable,
  output logic pdm_sample_a,
  output logic pdm_sample_b,
  output logic pdm_sample_valid
);

  // Source for one channel; converter setting is looked at first
  function automatic ipm_pkg::ipm_src_t path_source(input logic adc_pd, input logic mic_pd);
    if (!adc_pd) begin
      return ipm_pkg::IPM_SRC_ADC;
    end else if (!mic_pd) begin
      return ipm_pkg::IPM_SRC_MIC;
    end else begin
      return ipm_pkg::IPM_SRC_NONE;
    end
  endfunction

  // True when a channel feeds from the microphone port
  function automatic logic wants_mic(input logic adc_pd, input logic mic_pd);
    return adc_pd & ~mic_pd;
  endfunction

  ipm_pkg::ipm_top_st_t st_q; // Registered state
  ipm_pkg::ipm_top_st_t st_d; // Next state
  logic rise_pulse; // Bit clock goes high at the next edge
  logic fall_pulse; // Bit clock goes low at the next edge

  // Divider runs only while the port is powered
  ipm_clock_divider #(
    .DIV_LO(DIV_LO),
    .DIV_HI(DIV_HI)
  ) u_div (
    .clock(clock),
    .reset_n(reset_n),
    .enable(st_q.port_on),
    .divide_select(pdm_clock_divide_select),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  // Next state of source select, power and capture
  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    // Per-channel source and digital power
    st_d.src_a = path_source(adc_powerdown_a, mic_powerdown_a);
    st_d.src_b = path_source(adc_powerdown_b, mic_powerdown_b);
    st_d.dig_on_a = ~(adc_powerdown_a & mic_powerdown_a);
    st_d.dig_on_b = ~(adc_powerdown_b & mic_powerdown_b);
    // Port is up when either channel reads the microphones
    st_d.port_on = wants_mic(adc_powerdown_a, mic_powerdown_a) |
                   wants_mic(adc_powerdown_b, mic_powerdown_b);
    // Pull stays on always; it is weak enough not to upset the line
    st_d.pull_en = `IPM_PULL_ON;
    if (!st_q.port_on) begin
      // Powered off: clock idles low and stale divider pulses are dropped
      st_d.bclk = `IPM_BCLK_IDLE;
    end else if (rise_pulse) begin
      // Left microphone has driven the low phase; take its bit now
      st_d.bclk = 1'b1;
      st_d.bit_a = pdm_data_in;
    end else if (fall_pulse) begin
      // Right microphone bit closes the pair
      st_d.bclk = `IPM_BCLK_IDLE;
      st_d.samp_a = st_q.bit_a;
      st_d.samp_b = pdm_data_in;
      st_d.valid = 1'b1;
    end
  end

  // State register; input pins are taken as synchronous already
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q.src_a <= ipm_pkg::IPM_SRC_ADC;
      st_q.src_b <= ipm_pkg::IPM_SRC_ADC;
      st_q.dig_on_a <= 1'b1;
      st_q.dig_on_b <= 1'b1;
      st_q.port_on <= 1'b0;
      st_q.bclk <= `IPM_BCLK_IDLE;
      st_q.bit_a <= `IPM_BIT_RST;
      st_q.samp_a <= `IPM_BIT_RST;
      st_q.samp_b <= `IPM_BIT_RST;
      st_q.valid <= 1'b0;
      st_q.pull_en <= `IPM_PULL_ON;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign path_a_source = st_q.src_a;
  assign path_b_source = st_q.src_b;
  assign path_a_digital_power_on = st_q.dig_on_a;
  assign path_b_digital_power_on = st_q.dig_on_b;
  assign mic_port_power_on = st_q.port_on;
  assign pdm_bit_clock_out = st_q.bclk;
  assign pdm_data_pull_enable = st_q.pull_en;
  assign pdm_sample_a = st_q.samp_a;
  assign pdm_sample_b = st_q.samp_b;
  assign pdm_sample_valid = st_q.valid;

  // Checks, all in the master clock domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Converter on wins over a powered microphone
  property p_adc_priority;
    !adc_powerdown_a && !mic_powerdown_a |=> path_a_source == ipm_pkg::IPM_SRC_ADC && path_a_digital_power_on;
  endproperty
  a_adc_priority: assert property (p_adc_priority) else $error("converter lost priority");

  // Microphone chosen for channel B when its converter is down
  property p_mic_select;
    adc_powerdown_b && !mic_powerdown_b |=> path_b_source == ipm_pkg::IPM_SRC_MIC && path_b_digital_power_on;
  endproperty
  a_mic_select: assert property (p_mic_select) else $error("microphone not selected");

  // Both down turns channel power off
  property p_both_down;
    adc_powerdown_a && mic_powerdown_a |=> !path_a_digital_power_on && path_a_source == ipm_pkg::IPM_SRC_NONE;
  endproperty
  a_both_down: assert property (p_both_down) else $error("channel power not off");

  // Port power follows either channel wanting the microphones
  property p_port_power;
    ((adc_powerdown_a && !mic_powerdown_a) || (adc_powerdown_b && !mic_powerdown_b)) == 1'b1
      |=> mic_port_power_on;
  endproperty
  a_port_power: assert property (p_port_power) else $error("port not powered");

  // Port stays down when no channel wants it
  property p_port_off;
    !((adc_powerdown_a && !mic_powerdown_a) || (adc_powerdown_b && !mic_powerdown_b)) |=> !mic_port_power_on;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port powered without need");

  // Clock low while port is off
  property p_clock_idle;
    !mic_port_power_on |=> !pdm_bit_clock_out;
  endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("bit clock moved while off");

  // Clock only rises while the port is powered
  property p_clock_gated;
    $rose(pdm_bit_clock_out) |-> $past(mic_port_power_on);
  endproperty
  a_clock_gated: assert property (p_clock_gated) else $error("bit clock rose while off");

  // Ratio two: high for exactly one cycle
  property p_div_two;
    $rose(pdm_bit_clock_out) && pdm_clock_divide_select == `IPM_SEL_DIV_LO && $past(pdm_clock_divide_select)
      == `IPM_SEL_DIV_LO |=> !pdm_bit_clock_out;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two wrong");

  // Ratio four: high for exactly two cycles
  property p_div_four;
    ($rose(pdm_bit_clock_out) && pdm_clock_divide_select && $past(pdm_clock_divide_select) && mic_port_power_on) ##1
      (pdm_clock_divide_select && mic_port_power_on) |-> pdm_bit_clock_out ##1 !pdm_bit_clock_out;
  endproperty
  a_div_four: assert property (p_div_four) else $error("divide by four high phase wrong");

  // Ratio four: low phase also two cycles
  property p_div_four_low;
    ($fell(pdm_bit_clock_out) && pdm_clock_divide_select && $past(pdm_clock_divide_select) && mic_port_power_on)
      ##1 (pdm_clock_divide_select && mic_port_power_on) |-> !pdm_bit_clock_out ##1 pdm_bit_clock_out;
  endproperty
  a_div_four_low: assert property (p_div_four_low) else $error("divide by four low phase wrong");

  // Left bit taken at the rising edge
  property p_rise_capture;
    $rose(pdm_bit_clock_out) |-> st_q.bit_a == $past(pdm_data_in);
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("left bit not captured");

  // Right bit taken at the falling edge, strobed with it
  property p_fall_capture;
    pdm_sample_valid |-> $fell(pdm_bit_clock_out) && pdm_sample_b == $past(pdm_data_in);
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("right bit not captured");

  // One strobe per period, paired with the left bit of that period
  property p_pairing;
    pdm_sample_valid |-> pdm_sample_a == $past(st_q.bit_a) ##1 !pdm_sample_valid;
  endproperty
  a_pairing: assert property (p_pairing) else $error("sample pairing wrong");

  // Weak pull held while the port stays powered down
  property p_pull;
    !mic_port_power_on ##1 !mic_port_power_on |-> pdm_data_pull_enable;
  endproperty
  a_pull: assert property (p_pull) else $error("data pull released");

  // Further checks on the select table, for the other channel as well
  // Converter on wins on channel B too
  property p_adc_priority_b;
    !adc_powerdown_b && !mic_powerdown_b |=> path_b_source == ipm_pkg::IPM_SRC_ADC && path_b_digital_power_on;
  endproperty
  a_adc_priority_b: assert property (p_adc_priority_b) else $error("converter lost priority on B");

  // Microphone chosen for channel A when its converter is down
  property p_mic_select_a;
    adc_powerdown_a && !mic_powerdown_a |=> path_a_source == ipm_pkg::IPM_SRC_MIC && path_a_digital_power_on;
  endproperty
  a_mic_select_a: assert property (p_mic_select_a) else $error("microphone not selected on A");

  // Both down turns channel B power off
  property p_both_down_b;
    adc_powerdown_b && mic_powerdown_b |=> !path_b_digital_power_on && path_b_source == ipm_pkg::IPM_SRC_NONE;
  endproperty
  a_both_down_b: assert property (p_both_down_b) else $error("channel B power not off");

  // No source means no digital power
  property p_none_unpowered_b;
    path_b_source == ipm_pkg::IPM_SRC_NONE |-> !path_b_digital_power_on;
  endproperty
  a_none_unpowered_b: assert property (p_none_unpowered_b) else $error("unsourced channel powered");

  // Capture port checks; data is ignored while the port is down
  // No strobe while the port is down
  property p_off_no_strobe;
    !mic_port_power_on |=> !pdm_sample_valid;
  endproperty
  a_off_no_strobe: assert property (p_off_no_strobe) else $error("strobe while port off");

  // Every strobe comes from a powered port
  property p_strobe_needs_port;
    pdm_sample_valid |-> $past(mic_port_power_on);
  endproperty
  a_strobe_needs_port: assert property (p_strobe_needs_port) else $error("strobe without port power");

  // Samples hold between strobes
  property p_samples_hold;
    !pdm_sample_valid |-> $stable(pdm_sample_a) && $stable(pdm_sample_b);
  endproperty
  a_samples_hold: assert property (p_samples_hold) else $error("samples moved without strobe");

  // A high bit clock needs a powered port
  property p_clock_needs_port;
    pdm_bit_clock_out |-> $past(mic_port_power_on);
  endproperty
  a_clock_needs_port: assert property (p_clock_needs_port) else $error("bit clock high while off");

  // Losing port power drops the clock one cycle later
  property p_off_clock_low;
    $fell(mic_port_power_on) |=> !pdm_bit_clock_out;
  endproperty
  a_off_clock_low: assert property (p_off_clock_low) else $error("clock not low after power off");

  // Ratio two: low for exactly one cycle
  property p_div_two_low;
    $fell(pdm_bit_clock_out) && $past(pdm_clock_divide_select) == `IPM_SEL_DIV_LO && $past(mic_port_power_on)
      && mic_port_power_on |=> pdm_bit_clock_out;
  endproperty
  a_div_two_low: assert property (p_div_two_low) else $error("divide by two low phase wrong");

  // A powered falling edge always delivers a pair
  property p_fall_strobes;
    $fell(pdm_bit_clock_out) && $past(mic_port_power_on) |-> pdm_sample_valid;
  endproperty
  a_fall_strobes: assert property (p_fall_strobes) else $error("falling edge without strobe");

  // Rising edge only opens a pair, it never strobes
  property p_rise_no_strobe;
    $rose(pdm_bit_clock_out) |-> !pdm_sample_valid;
  endproperty
  a_rise_no_strobe: assert property (p_rise_no_strobe) else $error("strobe on rising edge");

  // Main scenarios
  c_div_two: cover property (pdm_sample_valid && pdm_clock_divide_select == `IPM_SEL_DIV_LO);
  c_div_four: cover property (pdm_sample_valid && pdm_clock_divide_select);
  c_both_mics: cover property (path_a_source == ipm_pkg::IPM_SRC_MIC && path_b_source == ipm_pkg::IPM_SRC_MIC
    && pdm_sample_valid);
  c_power_off: cover property ($fell(mic_port_power_on));
  // Ratio switched while the clock runs
  c_ratio_change: cover property (mic_port_power_on && $changed(pdm_clock_divide_select));

endmodule // ipm_input_path
`default_nettype wire

// ===== bench/ipm_mic_pair.sv
`timescale 1ns/1ps
`default_nettype none

// Two microphones sharing one data line, left in low phase, right in high phase
module ipm_mic_pair (
  input wire logic clock,
  input wire logic bit_clock,
  input wire logic right_present,
  output logic data,
  output logic drive_n
);
  logic [15:0] lfsr_q = 16'hace1; // Own bit source
  logic clk_q = 1'b0; // Bit clock seen last cycle
  logic [3:0] idle_q = 4'h0; // Cycles without a bit clock edge
  logic bit_l = 1'b0; // Left mic current bit
  logic bit_r = 1'b0; // Right mic current bit

  // New bit once a slot is over; a stopped clock powers both mics down
  always @(posedge clock) begin
    clk_q <= bit_clock;
    lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    if (bit_clock != clk_q) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hf) begin
      idle_q <= idle_q + 4'h1;
    end
    if (bit_clock && !clk_q) begin
      bit_l <= lfsr_q[1];
    end
    if (!bit_clock && clk_q) begin
      bit_r <= lfsr_q[0];
    end
  end

  // Handover follows the clock level at once, so release never lags the other drive
  assign data = bit_clock ? bit_r : bit_l;
  assign drive_n = (idle_q == 4'hf) || (bit_clock && !right_present);
endmodule // ipm_mic_pair

`default_nettype wire

// ===== bench/ipm_input_path_test.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: source table, port power, bit clock and capture
module ipm_input_path_test;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] pd = 4'h0; // Power-downs {mic b, mic a, adc b, adc a}
  logic sel = 1'b0; // Divide select
  logic right_on = 1'b1; // Right mic fitted
  logic [31:0] rng = 32'h2b; // Xorshift state
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi = 0; // Cycles of bit clock high
  int nv = 0; // Valid strobes seen
  logic ln, b0, po, s0, la;
  logic clean = 1'b0; // No ratio change in this high phase
  ipm_pkg::ipm_src_t src_a, src_b;
  logic dig_a, dig_b, port_on, bclk, pull, sa, sb, sv, mic_d, mic_dn;
  wire line; // Shared data line with weak pull-up
  assign line = !mic_dn ? mic_d : (pull ? 1'b1 : 1'bz);

  ipm_input_path u_ipm_input_path (.clock(clock), .reset_n(reset_n), .adc_powerdown_a(pd[0]),
    .adc_powerdown_b(pd[1]), .mic_powerdown_a(pd[2]), .mic_powerdown_b(pd[3]),
    .pdm_clock_divide_select(sel), .pdm_data_in(line), .path_a_source(src_a), .path_b_source(src_b),
    .path_a_digital_power_on(dig_a), .path_b_digital_power_on(dig_b), .mic_port_power_on(port_on),
    .pdm_bit_clock_out(bclk), .pdm_data_pull_enable(pull), .pdm_sample_a(sa), .pdm_sample_b(sb),
    .pdm_sample_valid(sv));
  ipm_mic_pair u_ipm_mic_pair (.clock(clock), .bit_clock(bclk), .right_present(right_on),
    .data(mic_d), .drive_n(mic_dn));

  // 200 MHz master clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  // Expected source of one channel
  function automatic ipm_pkg::ipm_src_t exp_src(logic adc, logic mic);
    return !adc ? ipm_pkg::IPM_SRC_ADC : (!mic ? ipm_pkg::IPM_SRC_MIC : ipm_pkg::IPM_SRC_NONE);
  endfunction

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic bad(logic [31:0] got, logic [31:0] exp);
    err_count++;
    $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask

  task automatic chk_bit(logic got, logic exp);
    num_checks++;
    if (got !== exp) bad(32'(got), 32'(exp));
  endtask

  task automatic chk_src(ipm_pkg::ipm_src_t got, ipm_pkg::ipm_src_t exp);
    num_checks++;
    if (got !== exp) bad(32'(got), 32'(exp));
  endtask

  task automatic chk_num(int got, int exp);
    num_checks++;
    if (got != exp) bad(got, exp);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test;
    end
  end

  // Watches every edge: idle clock, pairing, strobe and half-period length
  always @(posedge clock) begin
    ln = line;
    b0 = bclk;
    po = port_on;
    s0 = sel;
    #1;
    if (reset_n) begin
      if (!po) chk_bit(bclk, 1'b0);
      if (!b0 && bclk) begin
        la = ln;
        hi = 0;
        clean = 1'b1;
      end else if (b0 && !bclk && po) begin
        chk_bit(sv, 1'b1);
        chk_bit(sa, la);
        chk_bit(sb, ln);
        if (clean) chk_num(hi, s0 ? 2 : 1);
      end else if (!(b0 && !bclk)) begin
        chk_bit(sv, 1'b0);
      end
      if (bclk) hi++;
      if (sel != s0) clean = 1'b0;
    end else begin
      clean = 1'b0;
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    chk_src(src_a, ipm_pkg::IPM_SRC_ADC);
    chk_bit(bclk, 1'b0);
    chk_bit(pull, 1'b1);
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    // Every power-down combination, converter setting outranking the mic one
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      pd <= i[3:0];
      repeat (2) @(posedge clock);
      #1;
      chk_src(src_a, exp_src(pd[0], pd[2]));
      chk_src(src_b, exp_src(pd[1], pd[3]));
      chk_bit(dig_a, !(pd[0] && pd[2]));
      chk_bit(dig_b, !(pd[1] && pd[3]));
      chk_bit(port_on, (pd[0] && !pd[2]) || (pd[1] && !pd[3]));
      chk_bit(pull, 1'b1);
    end
    $display("test select done");
    // Both ratios, one or two mics, port powered from either channel
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      pd <= k[1] ? 4'h2 : 4'h1;
      sel <= k[0];
      right_on <= k[0] ^ k[1];
      nv = 0;
      repeat (64) begin
        @(posedge clock);
        #1;
        nv += int'(sv);
      end
      chk_bit(nv >= 64 / (k[0] ? 4 : 2) - 2, 1'b1);
    end
    $display("test capture done");
    // Random settings with a reset in mid-run
    for (int j = 0; j < 60; j++) begin
      rng = xs(rng);
      @(posedge clock);
      pd <= rng[3:0];
      sel <= rng[4];
      right_on <= rng[5];
      reset_n <= (j != 30);
      repeat (8 + int'(rng[9:6])) @(posedge clock);
      reset_n <= 1'b1;
    end
    $display("test random done");
    finish_test;
  end
endmodule // ipm_input_path_test

`default_nettype wire
